/* dv/rxbm_asserts.sv */
// assertions on the bus master side of the receive buffer manager
`timescale 1ns/1ps
module rxbm_asserts (
    // clock and reset
    input wire logic        clk_sys,
    input wire logic        arst_n,
    // bus master
    input wire logic        bm_req,
    input wire logic        bm_write,
    input wire logic        bm_from_fifo,
    input wire logic [31:0] bm_addr,
    input wire logic [15:0] bm_len,
    input wire logic [31:0] bm_wdata,
    input wire logic        transfer_complete
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    logic [31:0] rd_addr_q;
    wire         wb = bm_req && bm_write && !bm_from_fifo;
    // last read address is the descriptor pointer in use
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n)
            rd_addr_q <= 32'h0;
        else if (bm_req && !bm_write)
            rd_addr_q <= bm_addr;
    end
    ////////////////////////////////////////////////////////////////////////
    req_hold_a: assert property (
        bm_req && !transfer_complete |=> bm_req
            && $stable({bm_write, bm_from_fifo, bm_addr, bm_len, bm_wdata}))
        else $error("burst request changed before completion");
    req_drop_a: assert property (
        bm_req && transfer_complete |=> !bm_req)
        else $error("burst request held after completion");
    wb_own_a: assert property (wb |-> bm_wdata[31])
        else $error("status writeback without ownership bit");
    more_clean_a: assert property (
        wb && bm_wdata[30] |-> bm_wdata[18:17] == 2'b00)
        else $error("receive status in a continued descriptor");
    wb_len_a: assert property (wb |-> bm_len == 16'h0004)
        else $error("status writeback length wrong");
    wb_addr_a: assert property (wb |-> bm_addr == rd_addr_q + 32'h4)
        else $error("status writeback not at current descriptor");
    frag_len_a: assert property (
        bm_req && bm_from_fifo |->
            bm_write && bm_len != 16'h0 && bm_len <= 16'h0800)
        else $error("fragment write length out of range");
    read_len_a: assert property (
        bm_req && !bm_write |-> bm_len inside {16'h4, 16'h8, 16'hc})
        else $error("descriptor read length wrong");
    ////////////////////////////////////////////////////////////////////////
    cover property (bm_req && bm_from_fifo && transfer_complete);
    cover property (wb && bm_wdata[30] && transfer_complete);
    cover property (bm_req && !bm_write && transfer_complete);
endmodule // rxbm_asserts

bind rxbm_engine rxbm_asserts u_asserts (
    .clk_sys          (clk_sys),
    .arst_n           (arst_n),
    .bm_req           (bm_req),
    .bm_write         (bm_write),
    .bm_from_fifo     (bm_from_fifo),
    .bm_addr          (bm_addr),
    .bm_len           (bm_len),
    .bm_wdata         (bm_wdata),
    .transfer_complete(transfer_complete)
);

/* dv/rxbm_engine_tb.sv */
// self-checking bench for the receive buffer manager
`timescale 1ns/1ps
`include "rxbm_consts.vh"
module rxbm_engine_tb;
    typedef struct {
        logic [15:0] len;
        logic        crc;
        logic        fae;
        logic [31:0] status;
    } rxbm_row_t;
    logic        clk_sys, arst_n, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, bm_addr, bm_wdata, bm_rdata, rd_q;
    logic        mac_byte_in, mac_pkt_end, mac_crc_err, frame_alignment_error;
    logic [15:0] mac_pkt_len, bm_len;
    logic        bm_req, bm_write, bm_from_fifo, transfer_complete, bm_rvalid;
    logic [3:0]  delay;
    logic        serr_q;
    int          err_count, checks_done, i;
    rxbm_row_t   rows [4];

    rxbm_engine u_dut (.clk_sys(clk_sys), .arst_n(arst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .mac_byte_in(mac_byte_in), .mac_pkt_end(mac_pkt_end),
        .mac_pkt_len(mac_pkt_len), .mac_crc_err(mac_crc_err),
        .frame_alignment_error(frame_alignment_error), .bm_req(bm_req),
        .bm_write(bm_write), .bm_from_fifo(bm_from_fifo), .bm_addr(bm_addr),
        .bm_len(bm_len), .bm_wdata(bm_wdata),
        .transfer_complete(transfer_complete), .bm_rvalid(bm_rvalid),
        .bm_rdata(bm_rdata));
    rxbm_host_mem u_mem (.clk_sys(clk_sys), .delay(delay), .bm_req(bm_req),
        .bm_write(bm_write), .bm_from_fifo(bm_from_fifo), .bm_addr(bm_addr),
        .bm_len(bm_len), .bm_wdata(bm_wdata),
        .transfer_complete(transfer_complete), .bm_rvalid(bm_rvalid),
        .bm_rdata(bm_rdata));
    ////////////////////////////////////////////////////////////////////////
    task check(input string what, input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task summarize();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            err_count++;
            summarize();
        end
        rd_q = prdata;
        serr_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task poll(input logic [7:0] a, input logic [31:0] m, v);
        int n;
        n = 0;
        do begin
            apb(1'b0, a, 32'h0);
            n++;
        end while ((rd_q & m) !== v && n < 400);
        check("awaited bits", rd_q & m, v);
    endtask
    task push(input int n, input logic e, input logic [15:0] len,
              input logic crc, fae);
        repeat (n) begin
            @(posedge clk_sys);
            mac_byte_in <= 1'b1;
        end
        @(posedge clk_sys);
        mac_byte_in <= 1'b0;
        mac_pkt_end <= e;
        mac_pkt_len <= len;
        mac_crc_err <= crc;
        frame_alignment_error <= fae;
        @(posedge clk_sys);
        mac_pkt_end <= 1'b0;
    endtask
    task desc(input int b, input logic [31:0] link, cmd, bp);
        u_mem.mem[b] = link;
        u_mem.mem[b + 1] = cmd;
        u_mem.mem[b + 2] = bp;
    endtask
    task go();
        apb(1'b1, `RXBM_OFS_DPTR, 32'h0);
        apb(1'b0, `RXBM_OFS_STAT, 32'h0);
        check("done flag", {31'h0, rd_q[3]}, 32'h0);
        apb(1'b1, `RXBM_OFS_CMD, 32'h1);
    endtask
    task stop();
        apb(1'b1, `RXBM_OFS_CMD, 32'h2);
        poll(`RXBM_OFS_STAT, 32'h7, 32'h0);
        apb(1'b1, `RXBM_OFS_ISR, 32'h3);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    initial begin
        {arst_n, psel, penable, pwrite, mac_byte_in, mac_pkt_end} = 6'h0;
        {mac_crc_err, frame_alignment_error, paddr, pwdata} = 42'h0;
        mac_pkt_len = 16'h0;
        delay = 4'h0;
        err_count = 0;
        checks_done = 0;
        rows[0] = '{16'd64, 1'b0, 1'b0, 32'h8000_0040};
        rows[1] = '{16'd100, 1'b1, 1'b0, 32'h8002_0064};
        rows[2] = '{16'd1, 1'b0, 1'b1, 32'h8004_0001};
        rows[3] = '{16'd255, 1'b1, 1'b1, 32'h8006_00ff};
        repeat (16) @(posedge clk_sys);
        arst_n <= 1'b1;
        apb(1'b0, `RXBM_OFS_CFG, 32'h0);
        check("config reset", rd_q, `RXBM_CFG_RST);
        apb(1'b0, `RXBM_OFS_STAT, 32'h0);
        check("state reset", rd_q, 32'h0);
        apb(1'b0, 8'h14, 32'h0);
        check("unmapped error", {31'h0, serr_q}, 32'h1);
        check("unmapped data", rd_q, 32'h0);
        apb(1'b1, `RXBM_OFS_CFG, 32'h0030_0100);
        apb(1'b0, `RXBM_OFS_CFG, 32'h0);
        check("config write", rd_q, 32'h0030_0100);
        for (i = 0; i < 4; i++) begin
            delay <= i[3:0];
            u_mem.frag_bytes = 0;
            desc(0, 32'h0, 32'h0000_0200, 32'h0000_0100);
            go();
            push(rows[i].len, 1'b1, rows[i].len, rows[i].crc, rows[i].fae);
            poll(`RXBM_OFS_ISR, 32'h1, 32'h1);
            check("final status", u_mem.mem[1], rows[i].status);
            check("drained", u_mem.frag_bytes, {16'h0, rows[i].len});
            apb(1'b0, `RXBM_OFS_STAT, 32'h0);
            check("packets left", {29'h0, rd_q[10:8]}, 32'h0);
            stop();
            apb(1'b0, `RXBM_OFS_STAT, 32'h0);
            check("done set", {31'h0, rd_q[3]}, 32'h1);
        end
        // packet spread over three buffers, first part below drain level
        u_mem.frag_bytes = 0;
        desc(0, 32'h10, 32'h80, 32'h100);
        desc(4, 32'h20, 32'h80, 32'h180);
        desc(8, 32'h0, 32'h80, 32'h200);
        go();
        push(200, 1'b0, 16'h0, 1'b0, 1'b0);
        repeat (50) @(posedge clk_sys);
        check("early drain", u_mem.frag_bytes, 32'h0);
        apb(1'b0, `RXBM_OFS_STAT, 32'h0);
        check("fifo bytes", {16'h0, rd_q[31:16]}, 32'd200);
        push(100, 1'b1, 16'd300, 1'b1, 1'b0);
        poll(`RXBM_OFS_ISR, 32'h1, 32'h1);
        check("first part", u_mem.mem[1], 32'hc000_0080);
        check("second part", u_mem.mem[5], 32'hc000_0080);
        check("last part", u_mem.mem[9], 32'h8002_002c);
        check("chain bytes", u_mem.frag_bytes, 32'd300);
        stop();
        // descriptor still owned by the host
        desc(0, 32'h0, 32'h8000_0200, 32'h100);
        go();
        poll(`RXBM_OFS_ISR, 32'h1, 32'h1);
        check("owned skipped", u_mem.frag_bytes, 32'd300);
        stop();
        // no descriptors: the fifo fills and overruns
        push(2049, 1'b0, 16'h0, 1'b0, 1'b0);
        poll(`RXBM_OFS_ISR, 32'h2, 32'h2);
        apb(1'b0, `RXBM_OFS_STAT, 32'h0);
        check("fifo cap", {16'h0, rd_q[31:16]}, 32'h800);
        // reset in mid-run clears the sticky status and the fifo
        arst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        arst_n <= 1'b1;
        apb(1'b0, `RXBM_OFS_ISR, 32'h0);
        check("isr reset", rd_q, 32'h0);
        apb(1'b0, `RXBM_OFS_STAT, 32'h0);
        check("stat reset", rd_q, 32'h0);
        summarize();
    end
endmodule // rxbm_engine_tb

/* dv/rxbm_host_mem.sv */
// host memory model answering the burst requests
`timescale 1ns/1ps
module rxbm_host_mem (
    // clock and answer delay
    input  wire logic        clk_sys,
    input  wire logic [3:0]  delay,
    // bus master
    input  wire logic        bm_req,
    input  wire logic        bm_write,
    input  wire logic        bm_from_fifo,
    input  wire logic [31:0] bm_addr,
    input  wire logic [15:0] bm_len,
    input  wire logic [31:0] bm_wdata,
    output logic             transfer_complete,
    output logic             bm_rvalid,
    output logic [31:0]      bm_rdata
);
    // descriptor words by word address, own cleared by the bench except in the owned-descriptor test
    logic [31:0] mem [0:255];
    int          frag_bytes;
    int          i;
    initial begin
        transfer_complete = 1'b0;
        bm_rvalid = 1'b0;
        bm_rdata = 32'h0;
        frag_bytes = 0;
        forever begin
            @(posedge clk_sys);
            if (bm_req) begin
                repeat (delay) @(posedge clk_sys);
                for (i = 0; !bm_write && i < bm_len / 4; i++) begin
                    bm_rvalid <= 1'b1;
                    bm_rdata <= mem[bm_addr[9:2] + i[7:0]];
                    @(posedge clk_sys);
                end
                // data line does not keep its last value once released
                bm_rvalid <= 1'b0;
                bm_rdata <= ~bm_rdata;
                if (bm_write && !bm_from_fifo)
                    mem[bm_addr[9:2]] <= bm_wdata;
                if (bm_from_fifo)
                    frag_bytes += bm_len;
                transfer_complete <= 1'b1;
                @(posedge clk_sys);
                transfer_complete <= 1'b0;
            end
        end
    end
endmodule // rxbm_host_mem

/* verilog/rxbm_consts.vh */
// constants of the receive buffer manager
`ifndef RXBM_CONSTS_VH
`define RXBM_CONSTS_VH
// register offsets (byte addresses)
`define RXBM_OFS_CMD    8'h00
`define RXBM_OFS_DPTR   8'h04
`define RXBM_OFS_CFG    8'h08
`define RXBM_OFS_ISR    8'h0c
`define RXBM_OFS_STAT   8'h10
// command register fields
`define RXBM_CMD_ENA    0
`define RXBM_CMD_DIS    1
// config register fields and reset value
`define RXBM_CFG_DRN_LO 0
`define RXBM_CFG_DRN_HI 11
`define RXBM_CFG_MXB_LO 20
`define RXBM_CFG_MXB_HI 22
`define RXBM_CFG_RST    32'h0000_0100
// interrupt status bits
`define RXBM_ISR_IDLE   0
`define RXBM_ISR_OVR    1
// descriptor cmdsts fields
`define RXBM_DS_OWN     31
`define RXBM_DS_MORE    30
`define RXBM_DS_FAE     18
`define RXBM_DS_CRC     17
// descriptor geometry in bytes
`define RXBM_DESC_BYTES 16'h000c
`define RXBM_WORD_BYTES 16'h0004
// fifo capacity in bytes and packet status depth
`define RXBM_FIFO_CAP   12'h800
`define RXBM_PQ_DEPTH   3'h4
`endif

/* verilog/rxbm_engine.v */
// receive descriptor and buffer manager with apb registers
//
// What this block does
// - drain only above level or whole packet
// - enable in idle fetches descriptor in burst
// - cache holds one buffer pointer and count
// - 32-bit pointer addresses current descriptor
// - done flag set on completion, cleared on load
// - packet count up at mac end, down processed
// - current packet byte count capped at capacity
// - drain ready: packets above zero or bytes above level
// - idle, enabled, not done: fetch, enter fetch
// - idle, enabled, done: refresh link, then advance
// - fetch done: owned idle event, else waits fifo
// - drain min of packet and buffer bytes
// - buffer full mid packet: writeback own and more
// - packet end: writeback own, final status, size
// - fragment returns to wait, status to advance
// - advance non-null: load link, clear done, fetch
// - advance null: set done, idle event, idle
// - status only in last descriptor, bytes written in each
// - out of descriptors: buffer, overrun flagged
//
// The register offsets and register access over APB were decided locally.
`timescale 1ns/1ps
`include "rxbm_consts.vh"
module rxbm_engine (
    // clock and reset
    input  wire        clk_sys,
    input  wire        arst_n,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    // mac fill side of the receive fifo
    input  wire        mac_byte_in,
    input  wire        mac_pkt_end,
    input  wire [15:0] mac_pkt_len,
    input  wire        mac_crc_err,
    input  wire        frame_alignment_error,
    // shared bus master
    output reg         bm_req,
    output reg         bm_write,
    output reg         bm_from_fifo,
    output reg  [31:0] bm_addr,
    output reg  [15:0] bm_len,
    output reg  [31:0] bm_wdata,
    input  wire        transfer_complete,
    input  wire        bm_rvalid,
    input  wire [31:0] bm_rdata
);

////////////////////////////////////////////////////////////////////////
localparam [2:0] ST_IDLE = 3'h0;
localparam [2:0] ST_REFR = 3'h1;
localparam [2:0] ST_FTCH = 3'h2;
localparam [2:0] ST_WAIT = 3'h3;
localparam [2:0] ST_BWR  = 3'h4;
localparam [2:0] ST_SWB  = 3'h5;
localparam [2:0] ST_ADV  = 3'h6;

reg  [2:0]  state_q;
reg         receive_enable_cmd_q;
reg  [31:0] current_desc_pointer_q;
reg         desc_done_flag_q;
reg  [31:0] receive_config_reg_q;
reg         isr_idle_q;
reg         isr_ovr_q;
// descriptor_cache: link, cmdsts, one pointer/count pair
reg  [31:0] cache_link_q;
reg  [31:0] cache_cmdsts_q;
reg  [15:0] buffer_bytes_left_q;
reg  [31:0] buffer_write_pointer_q;
reg  [1:0]  word_idx_q;
// fifo accounting
reg  [11:0] fifo_fill_q;
reg  [2:0]  fifo_packet_count_q;
reg  [15:0] drained_q;
reg  [15:0] written_q;
reg  [17:0] pq_mem [0:3];
reg  [1:0]  pq_wr_q;
reg  [1:0]  pq_rd_q;

wire [11:0] drain_level;
wire [2:0]  max_burst_field;
wire [17:0] head;
reg  [15:0] fifo_packet_bytes;
reg  [15:0] pkt_rest;
wire        drain_ready;
wire [15:0] xfer_len;
wire [15:0] desc_len;
wire        pkt_closed;

assign drain_level     = receive_config_reg_q[`RXBM_CFG_DRN_HI:
                                              `RXBM_CFG_DRN_LO];
assign max_burst_field = receive_config_reg_q[`RXBM_CFG_MXB_HI:
                                              `RXBM_CFG_MXB_LO];
assign head            = pq_mem[pq_rd_q];

////////////////////////////////////////////////////////////////////////
// apb slave, zero wait states
wire acc    = psel & penable;
wire wr_en  = acc & pwrite;
wire mapped = (paddr == `RXBM_OFS_CMD) | (paddr == `RXBM_OFS_DPTR) |
              (paddr == `RXBM_OFS_CFG) | (paddr == `RXBM_OFS_ISR) |
              (paddr == `RXBM_OFS_STAT);
wire wr_cmd  = wr_en & (paddr == `RXBM_OFS_CMD);
wire wr_dptr = wr_en & (paddr == `RXBM_OFS_DPTR);
wire wr_cfg  = wr_en & (paddr == `RXBM_OFS_CFG);
wire wr_isr  = wr_en & (paddr == `RXBM_OFS_ISR);

// every access completes in its first access cycle
assign pready  = 1'b1;
assign pslverr = acc & ~mapped;

// read data is taken in the setup cycle so that it comes from a flop
// and stands unchanged through the access cycle
reg  [31:0] rd_mux;
always @* begin
    rd_mux = 32'h0000_0000;
    case (paddr)
        `RXBM_OFS_CMD:  rd_mux = {31'h0, receive_enable_cmd_q};
        `RXBM_OFS_DPTR: rd_mux = current_desc_pointer_q;
        `RXBM_OFS_CFG:  rd_mux = receive_config_reg_q;
        `RXBM_OFS_ISR:  rd_mux = {30'h0, isr_ovr_q, isr_idle_q};
        `RXBM_OFS_STAT: rd_mux = {fifo_packet_bytes,
                                  5'h00, fifo_packet_count_q,
                                  4'h0, desc_done_flag_q, state_q};
        default:        rd_mux = 32'h0000_0000;
    endcase
end

always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n)
        prdata <= 32'h0000_0000;
    else if (psel & ~penable & ~pwrite)
        prdata <= rd_mux;
    else
        prdata <= 32'h0000_0000;
end

////////////////////////////////////////////////////////////////////////
// drain condition and transfer lengths
// bytes lost to an overrun never come out, so the head packet counts
// no more than the fifo really holds
always @* begin
    pkt_rest = head[15:0] - drained_q;
    if ((fifo_packet_count_q != 3'h0) &&
        (pkt_rest < {4'h0, fifo_fill_q}))
        fifo_packet_bytes = pkt_rest;
    else
        fifo_packet_bytes = {4'h0, fifo_fill_q};
end

assign drain_ready = (fifo_packet_count_q != 3'h0) |
                     (fifo_packet_bytes > {4'h0, drain_level});
assign xfer_len = (fifo_packet_bytes < buffer_bytes_left_q) ?
                  fifo_packet_bytes : buffer_bytes_left_q;
// a zero field asks for the whole descriptor
assign desc_len = (max_burst_field == 3'h0) ? `RXBM_DESC_BYTES :
                  (({13'h0, max_burst_field} << 2) < `RXBM_DESC_BYTES) ?
                  ({13'h0, max_burst_field} << 2) : `RXBM_DESC_BYTES;
assign pkt_closed = (fifo_packet_count_q != 3'h0) &
                    (fifo_packet_bytes == 16'h0000);

// status words written back: own always set, more marks a continued
// packet, mac errors only in the last one, the bytes written to its buffer in each
wire [31:0] more_status  = {2'b11, 14'h0000, written_q};
wire [31:0] final_status = {2'b10, 11'h000, head[17], head[16], 1'b0,
                            written_q};

// a completion only counts while a request stands
wire ev_xfer = bm_req & transfer_complete;
wire drain_done = ev_xfer & (state_q == ST_BWR);
wire final_done = ev_xfer & (state_q == ST_SWB) &
                  ~cache_cmdsts_q[`RXBM_DS_MORE];
wire fifo_full  = (fifo_fill_q == `RXBM_FIFO_CAP);
wire pq_full    = (fifo_packet_count_q == `RXBM_PQ_DEPTH);

////////////////////////////////////////////////////////////////////////
// fifo accounting
always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
        fifo_fill_q         <= 12'h000;
        fifo_packet_count_q <= 3'h0;
        drained_q           <= 16'h0000;
        pq_wr_q             <= 2'h0;
        pq_rd_q             <= 2'h0;
    end else begin
        // bytes keep landing while no descriptor drains them
        fifo_fill_q <= fifo_fill_q
                       + {11'h0, mac_byte_in & ~fifo_full}
                       - (drain_done ? bm_len[11:0] : 12'h000);
        if (drain_done)
            drained_q <= drained_q + bm_len;
        else if (final_done)
            drained_q <= 16'h0000;
        // ends beyond the queue depth are dropped and flagged as overrun
        if (mac_pkt_end & ~pq_full) begin
            pq_mem[pq_wr_q] <= {frame_alignment_error, mac_crc_err,
                                mac_pkt_len};
            pq_wr_q         <= pq_wr_q + 2'h1;
        end
        if (final_done)
            pq_rd_q <= pq_rd_q + 2'h1;
        fifo_packet_count_q <= fifo_packet_count_q
                               + {2'h0, mac_pkt_end & ~pq_full}
                               - {2'h0, final_done};
    end
end

////////////////////////////////////////////////////////////////////////
// registers and the receive state machine
always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
        state_q                <= ST_IDLE;
        receive_enable_cmd_q   <= 1'b0;
        current_desc_pointer_q <= 32'h0000_0000;
        desc_done_flag_q       <= 1'b0;
        receive_config_reg_q   <= `RXBM_CFG_RST;
        isr_idle_q             <= 1'b0;
        isr_ovr_q              <= 1'b0;
        cache_link_q           <= 32'h0000_0000;
        cache_cmdsts_q         <= 32'h0000_0000;
        buffer_bytes_left_q    <= 16'h0000;
        buffer_write_pointer_q <= 32'h0000_0000;
        word_idx_q             <= 2'h0;
        written_q              <= 16'h0000;
        bm_req                 <= 1'b0;
        bm_write               <= 1'b0;
        bm_from_fifo           <= 1'b0;
        bm_addr                <= 32'h0000_0000;
        bm_len                 <= 16'h0000;
        bm_wdata               <= 32'h0000_0000;
    end else begin
        if (wr_cmd & pwdata[`RXBM_CMD_ENA])
            receive_enable_cmd_q <= 1'b1;
        else if (wr_cmd & pwdata[`RXBM_CMD_DIS])
            receive_enable_cmd_q <= 1'b0;
        if (wr_cfg)
            receive_config_reg_q <= pwdata;
        if (wr_dptr) begin
            current_desc_pointer_q <= pwdata;
            desc_done_flag_q       <= 1'b0;
        end
        // set wins over a write-one clear
        if (wr_isr & pwdata[`RXBM_ISR_OVR])
            isr_ovr_q <= 1'b0;
        // a byte or a packet end that finds no room is lost
        if ((mac_byte_in & fifo_full) | (mac_pkt_end & pq_full))
            isr_ovr_q <= 1'b1;
        if (wr_isr & pwdata[`RXBM_ISR_IDLE])
            isr_idle_q <= 1'b0;
        // descriptor words arrive link, cmdsts, buffer pointer
        if (bm_rvalid & bm_req & ~bm_write) begin
            word_idx_q <= word_idx_q + 2'h1;
            case (word_idx_q)
                2'h0: cache_link_q <= bm_rdata;
                2'h1: begin
                    cache_cmdsts_q      <= bm_rdata;
                    buffer_bytes_left_q <= bm_rdata[15:0];
                end
                2'h2: buffer_write_pointer_q <= bm_rdata;
                default: word_idx_q <= word_idx_q;
            endcase
        end
        if (ev_xfer)
            bm_req <= 1'b0;
        case (state_q)
            ST_IDLE: begin
                if (receive_enable_cmd_q) begin
                    word_idx_q   <= 2'h0;
                    bm_req       <= 1'b1;
                    bm_write     <= 1'b0;
                    bm_from_fifo <= 1'b0;
                    bm_addr      <= current_desc_pointer_q;
                    if (desc_done_flag_q) begin
                        bm_len  <= `RXBM_WORD_BYTES;
                        state_q <= ST_REFR;
                    end else begin
                        bm_len  <= desc_len;
                        state_q <= ST_FTCH;
                    end
                end
            end
            ST_REFR: begin
                if (ev_xfer)
                    state_q <= ST_ADV;
            end
            ST_FTCH: begin
                if (ev_xfer) begin
                    written_q <= 16'h0000;
                    if (cache_cmdsts_q[`RXBM_DS_OWN]) begin
                        isr_idle_q <= 1'b1;
                        state_q    <= ST_IDLE;
                    end else begin
                        state_q <= ST_WAIT;
                    end
                end
            end
            ST_WAIT: begin
                // prepared every cycle, used only once a writeback starts
                bm_addr <= current_desc_pointer_q + 32'h0000_0004;
                if ((buffer_bytes_left_q == 16'h0000) &
                    (fifo_packet_bytes != 16'h0000)) begin
                    bm_req       <= 1'b1;
                    bm_write     <= 1'b1;
                    bm_from_fifo <= 1'b0;
                    bm_len       <= `RXBM_WORD_BYTES;
                    bm_wdata     <= more_status;
                    cache_cmdsts_q[`RXBM_DS_MORE] <= 1'b1;
                    state_q      <= ST_SWB;
                end else if (pkt_closed) begin
                    bm_req       <= 1'b1;
                    bm_write     <= 1'b1;
                    bm_from_fifo <= 1'b0;
                    bm_len       <= `RXBM_WORD_BYTES;
                    bm_wdata     <= final_status;
                    cache_cmdsts_q[`RXBM_DS_MORE] <= 1'b0;
                    state_q      <= ST_SWB;
                end else if (drain_ready &
                             (fifo_packet_bytes != 16'h0000)) begin
                    bm_req       <= 1'b1;
                    bm_write     <= 1'b1;
                    bm_from_fifo <= 1'b1;
                    bm_addr      <= buffer_write_pointer_q;
                    bm_len       <= xfer_len;
                    buffer_bytes_left_q <= buffer_bytes_left_q - xfer_len;
                    state_q      <= ST_BWR;
                end
            end
            ST_BWR: begin
                if (ev_xfer) begin
                    buffer_write_pointer_q <= buffer_write_pointer_q
                                              + {16'h0, bm_len};
                    written_q <= written_q + bm_len;
                    state_q   <= ST_WAIT;
                end
            end
            ST_SWB: begin
                if (ev_xfer)
                    state_q <= ST_ADV;
            end
            ST_ADV: begin
                if (cache_link_q != 32'h0000_0000) begin
                    current_desc_pointer_q <= cache_link_q;
                    desc_done_flag_q <= 1'b0;
                    word_idx_q   <= 2'h0;
                    bm_req       <= 1'b1;
                    bm_write     <= 1'b0;
                    bm_from_fifo <= 1'b0;
                    bm_addr      <= cache_link_q;
                    bm_len       <= desc_len;
                    state_q      <= ST_FTCH;
                end else begin
                    // a pointer load in the same cycle keeps it clear
                    desc_done_flag_q <= ~wr_dptr;
                    isr_idle_q       <= 1'b1;
                    state_q          <= ST_IDLE;
                end
            end
            default: state_q <= ST_IDLE;
        endcase
    end
end

endmodule // rxbm_engine
